// *** rtl/baud_tick.sv ***
// Oversampling enable generator: one pulse every divisor pclk cycles.
// Assumes pclk is the single master clock; divisor zero stops the ticks.
`timescale 1ns/1ns
module baud_tick #(
  parameter int W = 16
) (
  // Clock and reset
  input  wire logic         pclk,
  input  wire logic         presetn,
  // Control
  input  wire logic         en,
  input  wire logic [W-1:0] divisor,
  // Enable out
  output logic              tick
);
  logic [W-1:0] cnt_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= '0;
      tick  <= 1'b0;
    end else if (!en || divisor == '0) begin
      cnt_q <= '0;
      tick  <= 1'b0;
    end else if (cnt_q >= divisor - 1'b1) begin
      cnt_q <= '0;
      tick  <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 1'b1;
      tick  <= 1'b0;
    end
  end
endmodule

// *** rtl/byte_queue.sv ***
// Byte queue of DEPTH entries, limited to one entry while deep is low.
// Assumes push and pop are single-cycle handshakes on pclk.
`timescale 1ns/1ns
module byte_queue
  import uart_pkg::*;
#(
  parameter int DEPTH = 16
) (
  // Clock and reset
  input  wire logic                       pclk,
  input  wire logic                       presetn,
  // Mode
  input  wire logic                       deep,
  input  wire logic                       flush,
  // Fill side
  input  wire logic                       push_valid,
  input  wire byte_t                      push_data,
  output logic                            push_ready,
  // Drain side
  output logic                            pop_valid,
  input  wire logic                       pop_ready,
  output byte_t                           pop_data,
  output logic [$clog2(DEPTH+1)-1:0]      count
);
  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH+1);

  function automatic logic [PW-1:0] next_ptr(input logic [PW-1:0] p);
    next_ptr = (p == PW'(DEPTH-1)) ? '0 : p + 1'b1;
  endfunction

  byte_t           mem_q [DEPTH];
  logic [PW-1:0]   wr_q;
  logic [PW-1:0]   rd_q;
  logic [CW-1:0]   cnt_q;
  logic            do_push;
  logic            do_pop;

  // Byte mode caps the queue at one so the holding register behaves classic
  assign push_ready = cnt_q < (deep ? CW'(DEPTH) : CW'(1));
  assign pop_valid  = cnt_q != '0;
  assign do_push    = push_valid & push_ready & ~flush;
  assign do_pop     = pop_ready & pop_valid & ~flush;
  assign pop_data   = mem_q[rd_q];
  assign count      = cnt_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else if (flush) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (do_push) begin
        wr_q <= next_ptr(wr_q);
      end
      if (do_pop) begin
        rd_q <= next_ptr(rd_q);
      end
      cnt_q <= cnt_q + CW'(do_push) - CW'(do_pop);
    end
  end

  // Storage has no reset; contents are undefined until written
  always_ff @(posedge pclk) begin
    if (do_push) begin
      mem_q[wr_q] <= push_data;
    end
  end
endmodule

// *** rtl/uart_defines.svh ***
// Offsets, field positions, reset values and timing counts of one serial port.
// Assumes word-aligned register indices on a 32-bit APB bus.
`ifndef UART_DEFINES_SVH
`define UART_DEFINES_SVH
// ****************************************
// Register indices (byte address = 4 x index)
// ****************************************
`define IDX_DATA     4'h0
`define IDX_IER      4'h1
`define IDX_QCTL     4'h2
`define IDX_LCR      4'h3
`define IDX_MCR      4'h4
`define IDX_LSR      4'h5
`define IDX_MSR      4'h6
`define IDX_SPR      4'h7
`define IDX_EVT      4'h8
`define IDX_EVT_MASK 4'h9
// ****************************************
// Field positions
// ****************************************
`define QC_ENABLE    0
`define QC_FLUSH_RX  1
`define QC_FLUSH_TX  2
`define LCR_DLE      7
`define LCR_BREAK    6
`define LCR_STOP2    2
`define MCR_DTR      0
`define MCR_RTS      1
`define MCR_IRDA     2
`define MCR_LOOP     4
`define MCR_RTSCTS   5
`define MCR_DTRDSR   7
`define IER_RX_RDY   0
`define IER_TX_RDY   1
`define IER_RX_STAT  2
`define IER_MODEM    3
`define IER_SLEEP    4
// ****************************************
// Reset values and timing
// ****************************************
`define IER_RST      8'h0C
`define LCR_RST      8'h00
`define MCR_RST      8'h00
`define DIV_RST      16'h0001
`define DEEP_DEPTH   16
`define TICKS_BIT    4'hF
`define TICKS_HALF   4'h7
`define IRDA_PULSE   4'h3
`endif

// *** rtl/uart_pkg.sv ***
// Types shared by the serial port design.
// Assumes the defines header supplies all numeric constants.
package uart_pkg;
  typedef logic [7:0] byte_t;
  typedef enum logic [3:0] {
    S_IDLE  = 4'b0001,
    S_START = 4'b0010,
    S_DATA  = 4'b0100,
    S_STOP  = 4'b1000
  } line_state_e;
endpackage

// *** rtl/uart_port.sv ***
// One serial port: APB register file, byte/deep queues, line engines.
// Assumes a zero-wait APB master on pclk and synchronous line inputs.
`timescale 1ns/1ns
`include "uart_defines.svh"

// Behaviour
// - Reset clears queue enable; byte mode
// - Queue enable gives sixteen-deep queues, else one
// - Deep mode adds hardware flow control, IrDA
// - Ten registers decoded via four-bit offset
// - Divisor access bit maps offsets 0/1 divisor
// - Offset 0 writes append, reads pop queue
// - Write to full transmit queue is dropped
// - Line status shows queue empty and full
// - Offsets 0 and 2 split read/write meaning
// - All baud ticks from one master clock
// - Every port instance behaves identically
// - Mode switch empties the receive queue
// - Byte mode uses receive trigger of one
module uart_port
  import uart_pkg::*;
#(
  parameter int DEPTH = `DEEP_DEPTH
) (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic [5:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Serial line
  output logic             txd,
  input  wire logic        rxd,
  output logic             rts_n,
  input  wire logic        cts_n,
  output logic             dtr_n,
  input  wire logic        dsr_n,
  input  wire logic        dcd_n,
  input  wire logic        ri_n,
  // Interrupt
  output logic             irq
);
  localparam int CW = $clog2(DEPTH+1);

  function automatic logic [CW-1:0] trig_level(input logic deep, input logic [1:0] sel);
    if (!deep) begin
      trig_level = CW'(1);
    end else begin
      case (sel)
        2'b00:   trig_level = CW'(1);
        2'b01:   trig_level = CW'(4);
        2'b10:   trig_level = CW'(8);
        default: trig_level = CW'(14);
      endcase
    end
  endfunction

  // ****************************************
  // Bus decode
  // ****************************************
  logic [3:0]  idx;
  logic        mapped;
  logic        setup;
  logic        acc;
  logic        wr;
  logic        rd;
  logic        divisor_access_bit;
  assign idx    = paddr[5:2];
  assign mapped = (idx <= `IDX_EVT_MASK) && (paddr[1:0] == 2'b00);
  assign setup  = psel & ~penable;
  assign acc    = psel & penable;
  assign wr     = acc & pwrite & mapped;
  assign rd     = acc & ~pwrite & mapped;
  assign pready  = 1'b1;
  assign pslverr = acc & ~mapped;

  byte_t       ier_q, lcr_q, mcr_q, spr_q, dll_q, dlm_q;
  logic [3:0]  evt_q, evt_mask_q, evt_set, cap_evt_q;
  logic        qen_q;
  logic [1:0]  trig_sel_q;
  logic        mode_chg, flush_rx, flush_tx;
  logic        tx_push, tx_full, tx_valid, tx_pop;
  logic        rx_push, rx_ready, rx_valid, rx_pop;
  byte_t       tx_head, rx_head, rx_byte;
  logic [CW-1:0] tx_cnt, rx_cnt;
  logic        pop_ok_q, lsr_overrun_q, lsr_frame_q;
  logic [3:0]  msr_prev_q, msr_delta_q, cap_delta_q;
  logic [1:0]  cap_lsr_q;
  byte_t       lsr_v, msr_v, isr_v;
  logic [31:0] rd_mux;
  logic        tick, rts_ok_q, flow_ok;
  line_state_e tx_st_q, rx_st_q;
  byte_t       tx_sh_q, rx_sh_q;
  logic [2:0]  tx_bit_q, rx_bit_q;
  logic [3:0]  tx_cnt_q, rx_tk_q, ir_q;
  logic        tx_raw, tx_line, rx_line;
  logic [2:0]  last_bit;
  logic        tx_full_n;

  assign divisor_access_bit = lcr_q[`LCR_DLE];

  // ****************************************
  // Configuration registers
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ier_q      <= `IER_RST;
      lcr_q      <= `LCR_RST;
      mcr_q      <= `MCR_RST;
      spr_q      <= '0;
      {dlm_q, dll_q} <= `DIV_RST;
      evt_mask_q <= '0;
    end else if (wr) begin
      case (idx)
        `IDX_DATA:     if (divisor_access_bit) dll_q <= pwdata[7:0];
        `IDX_IER:      if (divisor_access_bit) dlm_q <= pwdata[7:0];
                       else ier_q <= {3'b000, pwdata[4:0]};
        `IDX_LCR:      lcr_q <= pwdata[7:0];
        `IDX_MCR:      mcr_q <= pwdata[7:0];
        `IDX_SPR:      spr_q <= pwdata[7:0];
        `IDX_EVT_MASK: evt_mask_q <= pwdata[3:0];
        default: ;
      endcase
    end
  end

  // ****************************************
  // Queue control (write-only at offset 2)
  // ****************************************
  assign mode_chg = wr && idx == `IDX_QCTL && pwdata[`QC_ENABLE] != qen_q;
  assign flush_rx = mode_chg |
                    (wr && idx == `IDX_QCTL && pwdata[`QC_FLUSH_RX] && qen_q);
  assign flush_tx = wr && idx == `IDX_QCTL && pwdata[`QC_FLUSH_TX] && qen_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      qen_q      <= 1'b0;
      trig_sel_q <= 2'b00;
    end else if (wr && idx == `IDX_QCTL) begin
      qen_q      <= pwdata[`QC_ENABLE];
      trig_sel_q <= pwdata[7:6];
    end
  end

  // ****************************************
  // Queues
  // ****************************************
  assign tx_push = wr && idx == `IDX_DATA && !divisor_access_bit;
  assign rx_pop  = rd && idx == `IDX_DATA && !divisor_access_bit && pop_ok_q;

  // Full queue refuses the push, so the written byte is simply lost
  byte_queue #(.DEPTH(DEPTH)) u_txq (
    .pclk       (pclk),
    .presetn    (presetn),
    .deep       (qen_q),
    .flush      (flush_tx),
    .push_valid (tx_push),
    .push_data  (pwdata[7:0]),
    .push_ready (tx_full_n),
    .pop_valid  (tx_valid),
    .pop_ready  (tx_pop),
    .pop_data   (tx_head),
    .count      (tx_cnt)
  );
  assign tx_full = ~tx_full_n;

  byte_queue #(.DEPTH(DEPTH)) u_rxq (
    .pclk       (pclk),
    .presetn    (presetn),
    .deep       (qen_q),
    .flush      (flush_rx),
    .push_valid (rx_push),
    .push_data  (rx_byte),
    .push_ready (rx_ready),
    .pop_valid  (rx_valid),
    .pop_ready  (rx_pop),
    .pop_data   (rx_head),
    .count      (rx_cnt)
  );

  // ****************************************
  // Status views
  // ****************************************
  assign lsr_v = {tx_full, ~tx_valid & tx_st_q == S_IDLE, ~tx_valid,
                  ~rx_ready, lsr_frame_q, 1'b0, lsr_overrun_q, rx_valid};
  assign msr_v = {~dcd_n, ~ri_n, ~dsr_n, ~cts_n, msr_delta_q};

  always_comb begin
    isr_v = {{2{qen_q}}, 6'b000001};
    if (ier_q[`IER_RX_STAT] && (lsr_overrun_q || lsr_frame_q)) begin
      isr_v[5:0] = 6'b000110;
    end else if (ier_q[`IER_RX_RDY] && rx_cnt >= trig_level(qen_q, trig_sel_q)) begin
      isr_v[5:0] = 6'b000100;
    end else if (ier_q[`IER_TX_RDY] && !tx_valid) begin
      isr_v[5:0] = 6'b000010;
    end else if (ier_q[`IER_MODEM] && |msr_delta_q) begin
      isr_v[5:0] = 6'b000000;
    end
  end

  always_comb begin
    rd_mux = '0;
    case (idx)
      `IDX_DATA:     rd_mux[7:0] = divisor_access_bit ? dll_q : rx_head;
      `IDX_IER:      rd_mux[7:0] = divisor_access_bit ? dlm_q : ier_q;
      `IDX_QCTL:     rd_mux[7:0] = isr_v;
      `IDX_LCR:      rd_mux[7:0] = lcr_q;
      `IDX_MCR:      rd_mux[7:0] = mcr_q;
      `IDX_LSR:      rd_mux[7:0] = lsr_v;
      `IDX_MSR:      rd_mux[7:0] = msr_v;
      `IDX_SPR:      rd_mux[7:0] = spr_q;
      `IDX_EVT:      rd_mux[3:0] = evt_q;
      `IDX_EVT_MASK: rd_mux[3:0] = evt_mask_q;
      default: ;
    endcase
  end

  // Read data is frozen in the setup cycle; side effects act on that snapshot
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata      <= '0;
      pop_ok_q    <= 1'b0;
      cap_evt_q   <= '0;
      cap_delta_q <= '0;
      cap_lsr_q   <= '0;
    end else if (setup && !pwrite) begin
      prdata      <= rd_mux;
      pop_ok_q    <= rx_valid;
      cap_evt_q   <= evt_q;
      cap_delta_q <= msr_delta_q;
      cap_lsr_q   <= {lsr_frame_q, lsr_overrun_q};
    end
  end

  // ****************************************
  // Sticky flags; a set in the clearing cycle wins
  // ****************************************
  assign evt_set = {mode_chg, rd && idx == `IDX_DATA && !divisor_access_bit && !pop_ok_q,
                    rx_push & ~rx_ready, tx_push & tx_full};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      evt_q <= '0;
    end else begin
      evt_q <= (evt_q & ~((rd && idx == `IDX_EVT) ? cap_evt_q : 4'h0)) | evt_set;
    end
  end

  assign irq = |(evt_q & evt_mask_q);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lsr_overrun_q <= 1'b0;
      lsr_frame_q   <= 1'b0;
    end else begin
      lsr_overrun_q <= (lsr_overrun_q & ~(rd && idx == `IDX_LSR && cap_lsr_q[0]))
                       | (rx_push & ~rx_ready);
      lsr_frame_q   <= (lsr_frame_q & ~(rd && idx == `IDX_LSR && cap_lsr_q[1]))
                       | (rx_push & ~rx_line);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      msr_prev_q  <= '0;
      msr_delta_q <= '0;
    end else begin
      msr_prev_q  <= msr_v[7:4];
      msr_delta_q <= (msr_delta_q & ~((rd && idx == `IDX_MSR) ? cap_delta_q : 4'h0))
                     | {msr_prev_q[3] ^ msr_v[7], msr_prev_q[2] & ~msr_v[6],
                        msr_prev_q[1] ^ msr_v[5], msr_prev_q[0] ^ msr_v[4]};
    end
  end

  // ****************************************
  // Baud ticks and flow control
  // ****************************************
  baud_tick #(.W(16)) u_baud (
    .pclk    (pclk),
    .presetn (presetn),
    .en      (~ier_q[`IER_SLEEP]),
    .divisor ({dlm_q, dll_q}),
    .tick    (tick)
  );

  // Hysteresis: stop the peer at the trigger, release only once drained
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rts_ok_q <= 1'b1;
    end else if (rx_cnt >= trig_level(qen_q, trig_sel_q)) begin
      rts_ok_q <= 1'b0;
    end else if (rx_cnt == '0) begin
      rts_ok_q <= 1'b1;
    end
  end

  assign rts_n   = ~(mcr_q[`MCR_RTS] & (~(qen_q & mcr_q[`MCR_RTSCTS]) | rts_ok_q));
  assign dtr_n   = ~(mcr_q[`MCR_DTR] & (~(qen_q & mcr_q[`MCR_DTRDSR]) | rts_ok_q));
  assign flow_ok = (~(qen_q & mcr_q[`MCR_RTSCTS]) | ~cts_n) &
                   (~(qen_q & mcr_q[`MCR_DTRDSR]) | ~dsr_n);

  // ****************************************
  // Transmit engine
  // ****************************************
  assign last_bit = 3'd4 + {1'b0, lcr_q[1:0]};
  assign tx_pop   = tx_st_q == S_IDLE && tx_valid && flow_ok;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_st_q  <= S_IDLE;
      tx_sh_q  <= '0;
      tx_bit_q <= '0;
      tx_cnt_q <= '0;
    end else if (tx_pop) begin
      tx_st_q  <= S_START;
      tx_sh_q  <= tx_head;
      tx_cnt_q <= '0;
    end else if (tick && tx_st_q != S_IDLE) begin
      tx_cnt_q <= tx_cnt_q + 1'b1;
      if (tx_cnt_q == `TICKS_BIT) begin
        case (tx_st_q)
          S_START: begin
            tx_st_q  <= S_DATA;
            tx_bit_q <= '0;
          end
          S_DATA: begin
            tx_sh_q  <= tx_sh_q >> 1;
            tx_bit_q <= tx_bit_q + 1'b1;
            if (tx_bit_q == last_bit) begin
              tx_st_q  <= S_STOP;
              tx_bit_q <= '0;
            end
          end
          S_STOP: begin
            tx_bit_q <= tx_bit_q + 1'b1;
            if (tx_bit_q[0] == lcr_q[`LCR_STOP2]) begin
              tx_st_q <= S_IDLE;
            end
          end
          default: tx_st_q <= S_IDLE;
        endcase
      end
    end
  end

  assign tx_raw  = (tx_st_q == S_START) ? 1'b0 :
                   (tx_st_q == S_DATA)  ? tx_sh_q[0] : 1'b1;
  // IrDA sends a short high pulse for each zero bit and idles low
  assign tx_line = (qen_q & mcr_q[`MCR_IRDA]) ?
                   (~tx_raw & (tx_cnt_q < `IRDA_PULSE)) : tx_raw;
  assign txd     = mcr_q[`MCR_LOOP] ? 1'b1 : (tx_line & ~lcr_q[`LCR_BREAK]);

  // ****************************************
  // Receive engine
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ir_q <= '0;
    end else if (rxd) begin
      ir_q <= `TICKS_BIT;
    end else if (tick && ir_q != '0) begin
      ir_q <= ir_q - 1'b1;
    end
  end

  assign rx_line = mcr_q[`MCR_LOOP] ? tx_raw :
                   (qen_q & mcr_q[`MCR_IRDA]) ? (ir_q == '0) : rxd;
  assign rx_push = tick && rx_st_q == S_STOP && rx_tk_q == `TICKS_BIT;
  assign rx_byte = rx_sh_q >> (2'd3 - lcr_q[1:0]);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_st_q  <= S_IDLE;
      rx_sh_q  <= '0;
      rx_bit_q <= '0;
      rx_tk_q  <= '0;
    end else if (tick) begin
      rx_tk_q <= rx_tk_q + 1'b1;
      case (rx_st_q)
        S_IDLE: begin
          rx_tk_q <= '0;
          if (!rx_line) begin
            rx_st_q <= S_START;
          end
        end
        S_START: if (rx_tk_q == `TICKS_HALF) begin
          rx_st_q  <= rx_line ? S_IDLE : S_DATA;
          rx_tk_q  <= '0;
          rx_bit_q <= '0;
        end
        S_DATA: if (rx_tk_q == `TICKS_BIT) begin
          rx_sh_q  <= {rx_line, rx_sh_q[7:1]};
          rx_bit_q <= rx_bit_q + 1'b1;
          if (rx_bit_q == last_bit) begin
            rx_st_q <= S_STOP;
          end
        end
        S_STOP: if (rx_tk_q == `TICKS_BIT) begin
          rx_st_q <= S_IDLE;
        end
        default: rx_st_q <= S_IDLE;
      endcase
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  reset_state_a: assert property ($rose(presetn) |->
    !qen_q && !lcr_q[`LCR_DLE] && rx_cnt == 0 && tx_cnt == 0)
    else $error("port not in byte mode after reset");
  depth_cap_a: assert property (
    rx_cnt <= (qen_q ? CW'(DEPTH) : CW'(1)) && tx_cnt <= (qen_q ? CW'(DEPTH) : CW'(1)))
    else $error("queue exceeds mode depth");
  tx_drop_a: assert property (tx_push && tx_full && !tx_pop |=>
    tx_cnt == $past(tx_cnt) && evt_q[0])
    else $error("write to full transmit queue not dropped");
  mode_flush_a: assert property (mode_chg |=> rx_cnt == 0 ##1 qen_q == $past(qen_q))
    else $error("receive queue not emptied on mode change");
  divisor_map_a: assert property (wr && idx == `IDX_DATA && divisor_access_bit |=>
    dll_q == $past(pwdata[7:0]) && tx_cnt == $past(tx_cnt))
    else $error("divisor access did not redirect offset 0");
  rx_pop_a: assert property (rx_pop && !rx_push && !flush_rx |=>
    rx_cnt == $past(rx_cnt) - 1'b1)
    else $error("receive read did not pop");
  full_flag_a: assert property (!rx_ready |-> lsr_v[4] && lsr_v[0])
    else $error("line status misses receive full");
  byte_trig_a: assert property (!qen_q && rx_valid && ier_q[`IER_RX_RDY] &&
    !lsr_overrun_q && !lsr_frame_q |-> isr_v[5:0] == 6'b000100)
    else $error("byte mode trigger is not one");
  isr_read_a: assert property (setup && !pwrite && idx == `IDX_QCTL |=>
    prdata[7:6] == {2{qen_q}} && prdata[0] == $past(isr_v[0]))
    else $error("offset 2 read is not interrupt source");
  cts_hold_a: assert property (qen_q && mcr_q[`MCR_RTSCTS] && cts_n |-> !tx_pop)
    else $error("transmit started against flow control");
  irq_out_a: assert property (|(evt_q & evt_mask_q) |-> irq ##1 (irq || $past(rd)))
    else $error("unmasked event without interrupt");
endmodule

// *** tb/serial_peer.sv ***
// Serial peer model: sends bytes on rxd, collects bytes seen on txd.
// Assumes divisor 1 (16 clocks a bit), eight data bits, one stop bit.
`timescale 1ns/1ns
module serial_peer
  import uart_pkg::*;
(
  // Clock
  input  wire logic pclk,
  // Line
  input  wire logic txd,
  output logic      rxd
);
  byte_t got[$];
  byte_t cap;
  initial rxd = 1'b1;
  // ****************************************
  // Frame out: start, data LSB first, stop
  // ****************************************
  task automatic send(input byte_t b);
    for (int i = -1; i < 9; i++) begin
      @(posedge pclk);
      rxd <= (i < 0) ? 1'b0 : (i > 7) ? 1'b1 : b[i];
      repeat (15) @(posedge pclk);
    end
  endtask
  // ****************************************
  // Frame in, sampled mid-bit
  // ****************************************
  always begin
    @(negedge txd);
    repeat (8) @(posedge pclk);
    for (int i = 0; i < 8; i++) begin
      repeat (16) @(posedge pclk);
      cap[i] = txd;
    end
    repeat (16) @(posedge pclk);
    got.push_back(cap);
  end
endmodule

// *** tb/testbench.sv ***
// Self-checking bench for one serial port over APB.
// Assumes a serial peer on the line; modem inputs start idle, then cts_n, dcd_n and ri_n go low.
`timescale 1ns/1ns
module testbench;
  import uart_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pslverr, pready, irq, txd, rxd;
  logic        rts_n, dtr_n, slv, cts_n, dsr_n, dcd_n, ri_n;
  logic [5:0]  paddr;
  logic [31:0] pwdata, prdata, r;
  int          fails, total_checks;
  uart_port dut_u (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .txd(txd), .rxd(rxd), .rts_n(rts_n), .cts_n(cts_n), .dtr_n(dtr_n),
    .dsr_n(dsr_n), .dcd_n(dcd_n), .ri_n(ri_n), .irq(irq));
  serial_peer peer_u (.pclk(pclk), .txd(txd), .rxd(rxd));
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  // ****************************************
  // Bus cycles and comparison
  // ****************************************
  task automatic apb(input logic w, input logic [3:0] idx, input byte_t d);
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= {idx, 2'b00};
    pwdata  <= {24'h0000_00, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r       = prdata;
    slv     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge pclk);
    fails++;
    test_done;
  end
  // ****************************************
  // Tests
  // ****************************************
  initial begin
    {psel, penable, pwrite, paddr, pwdata, fails, total_checks} = '0;
    {cts_n, dsr_n, dcd_n, ri_n} = 4'hF;
    presetn = 1'b0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, 4'h1, 0); chk(r, 32'h0000_000C);
    apb(0, 4'h3, 0); chk(r, 32'h0000_0000);
    chk({30'h0, rts_n, dtr_n}, 32'h0000_0003);
    apb(0, 4'h5, 0); chk(r & 32'h0000_0061, 32'h0000_0060);
    apb(0, 4'hA, 0); chk({31'h0, slv}, 32'h0000_0001);
    apb(1, 4'h7, 8'h5A); apb(0, 4'h7, 0); chk(r, 32'h0000_005A);
    // Divisor latch behind offsets 0 and 1
    apb(1, 4'h3, 8'h80);
    apb(0, 4'h0, 0); chk(r, 32'h0000_0001);
    apb(1, 4'h1, 8'h12); apb(0, 4'h1, 0); chk(r, 32'h0000_0012);
    apb(1, 4'h1, 8'h00);
    apb(1, 4'h3, 8'h03); apb(0, 4'h1, 0); chk(r, 32'h0000_000C);
    apb(1, 4'h1, 8'h01);
    // Byte mode holds one received byte: second one overruns
    peer_u.send(8'hC3);
    peer_u.send(8'h3C);
    repeat (20) @(posedge pclk);
    apb(0, 4'h5, 0); chk(r & 32'h0000_0013, 32'h0000_0013);
    apb(0, 4'h2, 0); chk(r, 32'h0000_0004);
    apb(0, 4'h8, 0); chk(r & 32'h0000_0002, 32'h0000_0002);
    // Entering deep mode flushes receive side
    apb(1, 4'h2, 8'h01);
    apb(0, 4'h5, 0); chk(r & 32'h0000_0001, 32'h0000_0000);
    apb(0, 4'h8, 0); chk(r & 32'h0000_0008, 32'h0000_0008);
    // Burst: shifter takes one, queue sixteen, last one dropped
    for (int i = 0; i < 18; i++) apb(1, 4'h0, 8'h40 + i[7:0]);
    apb(0, 4'h5, 0); chk(r & 32'h0000_0080, 32'h0000_0080);
    // Interrupt level settles after the access edge, so look half a cycle later
    apb(1, 4'h9, 8'h00);
    @(negedge pclk);
    chk({31'h0, irq}, 32'h0000_0000);
    apb(1, 4'h9, 8'h01);
    @(negedge pclk);
    chk({31'h0, irq}, 32'h0000_0001);
    apb(0, 4'h8, 0); chk(r, 32'h0000_0001);
    @(negedge pclk);
    chk({31'h0, irq}, 32'h0000_0000);
    for (int k = 0; k < 4000 && peer_u.got.size() < 17; k++) @(posedge pclk);
    repeat (400) @(posedge pclk);
    chk(peer_u.got.size(), 32'd17);
    foreach (peer_u.got[i]) chk(peer_u.got[i], 32'h40 + i);
    // Deep receive keeps order; empty read is flagged
    peer_u.send(8'hA5);
    peer_u.send(8'h3C);
    repeat (20) @(posedge pclk);
    apb(0, 4'h5, 0); chk(r & 32'h0000_0013, 32'h0000_0001);
    apb(0, 4'h0, 0); chk(r, 32'h0000_00A5);
    apb(0, 4'h0, 0); chk(r, 32'h0000_003C);
    apb(0, 4'h0, 0);
    apb(0, 4'h8, 0); chk(r, 32'h0000_0004);
    // Clear-to-send off holds the transmitter in deep mode
    apb(1, 4'h4, 8'h23);
    @(negedge pclk);
    chk({30'h0, rts_n, dtr_n}, 32'h0000_0000);
    apb(1, 4'h0, 8'h66);
    repeat (40) @(posedge pclk);
    apb(0, 4'h5, 0); chk(r & 32'h0000_0060, 32'h0000_0000);
    cts_n <= 1'b0;
    dcd_n <= 1'b0;
    ri_n  <= 1'b0;
    for (int k = 0; k < 400 && peer_u.got.size() < 18; k++) @(posedge pclk);
    chk(peer_u.got.size(), 32'd18);
    chk(peer_u.got[17], 32'h0000_0066);
    // Modem status: levels plus sticky deltas cleared by the read
    apb(0, 4'h6, 0); chk(r, 32'h0000_00D9);
    apb(0, 4'h6, 0); chk(r, 32'h0000_00D0);
    apb(0, 4'h2, 0); chk(r & 32'h0000_00C0, 32'h0000_00C0);
    // Reset again in mid-run: byte mode, divisor access off, queues empty
    apb(1, 4'h3, 8'h80);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, 4'h2, 0); chk(r & 32'h0000_00C0, 32'h0000_0000);
    apb(0, 4'h3, 0); chk(r, 32'h0000_0000);
    apb(0, 4'h5, 0); chk(r & 32'h0000_0061, 32'h0000_0060);
    test_done;
  end
endmodule
